// File: include/tcb_pkg.sv
// constants and types shared by the compare-buffer timer block
package tcb_pkg;
   localparam int unsigned CNT_W         = 16;             // counter width
   localparam int unsigned BYTE_W        = 8;              // register byte
   localparam int unsigned MODE_W        = 3;              // mode field
   localparam int unsigned CLKSEL_W      = 2;              // source select
   localparam logic [15:0] COUNT_CLEAR   = 16'h0000;       // cleared count
   localparam logic [15:0] COMPARE_RESET = 16'hFFFF;       // compare reset
   localparam logic [7:0]  LOW_RESET     = 8'hFF;          // temp reset
   localparam logic [2:0]  MODE_EXT_TRIG = 3'h4;           // "100"
   localparam logic [2:0]  MODE_EVENT    = 3'h2;           // "010"
   localparam logic [2:0]  MODE_WINDOW   = 3'h5;           // "101"
   localparam logic [2:0]  MODE_RESET    = 3'h0;           // mode at reset
   localparam logic [1:0]  CLKSEL_RESET  = 2'h0;           // select at reset
   // source clock prescale: terminal counts for dividers 1024, 64, 4, 2
   localparam logic [9:0]  DIV_SEL0      = 10'h3FF;
   localparam logic [9:0]  DIV_SEL1      = 10'h03F;
   localparam logic [9:0]  DIV_SEL2      = 10'h003;
   localparam logic [9:0]  DIV_SEL3      = 10'h001;
   // external trigger sequencing
   typedef enum logic [1:0] {
      TCB_IDLE,
      TCB_WAIT,
      TCB_COUNT
   } tcb_state_t;
endpackage : tcb_pkg

// File: rtl/tcb_pin_sync.sv
// input pin synchroniser with edge detection
module tcb_pin_sync
   import tcb_pkg::*;
(
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);
   ////////////////////////////////////////////////////////////////////////
   logic meta;       // first stage, read only by the second stage
   logic sync;       // second stage, safe level
   logic prev;       // delayed copy for edge detection
   logic next_meta;
   logic next_sync;
   logic next_prev;

   // next values of the chain
   always_comb
   begin
      next_meta = i_pin;
      next_sync = meta;
      next_prev = sync;
   end

   // registers of the chain
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end
      else
      begin
         meta <= next_meta;
         sync <= next_sync;
         prev <= next_prev;
      end
   end

   // edges only look at the second and third stages
   assign o_level = sync;
   assign o_rise  = sync & ~prev;
   assign o_fall  = ~sync & prev;
endmodule : tcb_pin_sync

// File: rtl/tcb_timer.sv
// 16-bit compare timer: buffered compare A, trigger/event/window modes
module tcb_timer
   import tcb_pkg::*;
(
   input  wire logic                i_core_clk,
   input  wire logic                i_rst,
   input  wire logic                i_external_input_pin,
   input  wire logic                i_run_bit,
   input  wire logic                i_compare_buffer_enable,
   input  wire logic                i_overflow_irq_enable,
   input  wire logic [MODE_W-1:0]   i_operation_mode_select,
   input  wire logic [CLKSEL_W-1:0] i_source_clock_select,
   input  wire logic                i_edge_level_select,
   input  wire logic                i_retrigger_stop_enable,
   input  wire logic                i_mode_wr,
   input  wire logic                i_compare_a_low_wr,
   input  wire logic                i_compare_a_high_wr,
   input  wire logic [BYTE_W-1:0]   i_wdata,
   output logic      [CNT_W-1:0]    o_compare_a_read,
   output logic      [CNT_W-1:0]    o_compare_a_active,
   output logic      [CNT_W-1:0]    o_count,
   output logic      [MODE_W-1:0]   o_timer_mode,
   output logic                     o_overflow_irq_enable,
   output logic                     o_running,
   output logic                     o_timer_irq
);
   ////////////////////////////////////////////////////////////////////////
   // pin conditioning
   logic pin_level;  // synchronised pin level
   logic pin_rise;   // one-cycle rising edge
   logic pin_fall;   // one-cycle falling edge

   tcb_pin_sync tcb_pin_sync_inst (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_pin      (i_external_input_pin),
      .o_level    (pin_level),
      .o_rise     (pin_rise),
      .o_fall     (pin_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [MODE_W-1:0]   mode;        // latched mode field
   logic [CLKSEL_W-1:0] clk_sel;     // latched source select
   logic                edge_sel;    // latched edge/level select
   logic                retrig;      // latched retrigger-stop
   logic                ovf_en;      // latched overflow enable
   logic                running;     // run bit as seen last cycle
   logic [CNT_W-1:0]    count;       // up counter
   logic [9:0]          prescale;    // source clock divider
   logic [BYTE_W-1:0]   low_tmp;     // low byte temporary store
   logic [CNT_W-1:0]    cmp_buf;     // double buffer
   logic [CNT_W-1:0]    cmp_act;     // active compare value
   logic                irq;         // one-cycle interrupt pulse
   tcb_state_t          trig_state;  // trigger sequencing

   logic [MODE_W-1:0]   next_mode;
   logic [CLKSEL_W-1:0] next_clk_sel;
   logic                next_edge_sel;
   logic                next_retrig;
   logic                next_ovf_en;
   logic                next_running;
   logic [CNT_W-1:0]    next_count;
   logic [9:0]          next_prescale;
   logic [BYTE_W-1:0]   next_low_tmp;
   logic [CNT_W-1:0]    next_cmp_buf;
   logic [CNT_W-1:0]    next_cmp_act;
   logic                next_irq;
   tcb_state_t          next_trig_state;

   // combined helpers
   logic                tick;        // source clock tick
   logic                sel_edge;    // selected edge seen
   logic                opp_edge;    // opposite edge seen
   logic                match;       // counter equals active compare
   logic [CNT_W-1:0]    new_value;   // committed 16-bit value

   // divider terminal for a source select
   function automatic logic [9:0] div_term(input logic [CLKSEL_W-1:0] s);
      case (s)
         2'h0:    div_term = DIV_SEL0;
         2'h1:    div_term = DIV_SEL1;
         2'h2:    div_term = DIV_SEL2;
         default: div_term = DIV_SEL3;
      endcase
   endfunction : div_term

   assign tick      = (prescale == div_term(clk_sel));
   assign sel_edge  = edge_sel ? pin_fall : pin_rise;
   assign opp_edge  = edge_sel ? pin_rise : pin_fall;
   assign match     = running && (count == cmp_act);
   assign new_value = {i_wdata, low_tmp};

   ////////////////////////////////////////////////////////////////////////
   // configuration: locked while running
   // the run bit is taken through a register, so a start or stop takes
   // effect one edge after software changes it; a mode write in the
   // cycle of a start is still accepted, which keeps set-then-start simple
   always_comb
   begin
      next_mode     = mode;
      next_clk_sel  = clk_sel;
      next_edge_sel = edge_sel;
      next_retrig   = retrig;
      next_ovf_en   = ovf_en;
      next_running  = i_run_bit;
      if (i_mode_wr && !running)
      begin
         next_mode     = i_operation_mode_select;
         next_clk_sel  = i_source_clock_select;
         next_edge_sel = i_edge_level_select;
         next_retrig   = i_retrigger_stop_enable;
      end
      if (!running)  // overflow enable frozen once started
         next_ovf_en = i_overflow_irq_enable;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         mode     <= MODE_RESET;
         clk_sel  <= CLKSEL_RESET;
         edge_sel <= 1'b0;
         retrig   <= 1'b0;
         ovf_en   <= 1'b0;
         running  <= 1'b0;
      end
      else
      begin
         mode     <= next_mode;
         clk_sel  <= next_clk_sel;
         edge_sel <= next_edge_sel;
         retrig   <= next_retrig;
         ovf_en   <= next_ovf_en;
         running  <= next_running;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // compare register with temporary store and double buffer
   // the low byte never reaches the compare path on its own: only the
   // high write commits, so a half-written value is never matched
   always_comb
   begin
      next_low_tmp = low_tmp;
      next_cmp_buf = cmp_buf;
      next_cmp_act = cmp_act;
      if (i_compare_a_low_wr)
         next_low_tmp = i_wdata;
      // a buffered match loads active from the buffer; a write in the same cycle wins
      if (i_compare_buffer_enable && match)
         next_cmp_act = cmp_buf;
      if (i_compare_a_high_wr)
      begin
         next_cmp_buf = new_value;
         if (!i_compare_buffer_enable)
            next_cmp_act = new_value;
         else if (!running)
            next_cmp_act = new_value;
         else if (match)
            next_cmp_act = new_value;
         // otherwise buffer only; active waits for the match
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         low_tmp <= LOW_RESET;
         cmp_buf <= COMPARE_RESET;
         cmp_act <= COMPARE_RESET;
      end
      else
      begin
         low_tmp <= next_low_tmp;
         cmp_buf <= next_cmp_buf;
         cmp_act <= next_cmp_act;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter, prescaler and trigger sequencing
   // the prescaler restarts from zero on every start, so the first tick
   // lands a full divider period after the run bit; a match always wins
   // over an edge or tick in the same cycle, clearing the count
   // limitation: no overflow event is raised here, a value below the
   // count simply waits for the wrap
   always_comb
   begin
      next_count      = count;
      next_prescale   = prescale;
      next_trig_state = trig_state;
      next_irq        = 1'b0;
      if (!running)
      begin
         // stop clears count and prescaler, sequencing back to wait
         next_count      = COUNT_CLEAR;
         next_prescale   = 10'h000;
         next_trig_state = TCB_WAIT;
      end
      else
      begin
         next_prescale = tick ? 10'h000 : prescale + 10'h001;
         if (match)
         begin
            next_irq   = 1'b1;
            next_count = COUNT_CLEAR;
         end
         else
         begin
            case (mode)
               MODE_EXT_TRIG:
               begin
                  case (trig_state)
                     TCB_WAIT:
                        if (sel_edge)
                           next_trig_state = TCB_COUNT;
                     TCB_COUNT:
                     begin
                        // edges matter only with retrigger-stop
                        if (retrig && opp_edge)
                        begin
                           next_count      = COUNT_CLEAR;
                           next_trig_state = TCB_WAIT;
                        end
                        else if (tick)
                           next_count = count + 16'h0001;
                     end
                     default:
                        next_trig_state = TCB_WAIT;
                  endcase
               end
               MODE_EVENT:
                  if (sel_edge)
                     next_count = count + 16'h0001;
               MODE_WINDOW:
                  // window level gates the source tick
                  if (tick && (pin_level ^ edge_sel))
                     next_count = count + 16'h0001;
               default:
                  // plain timer count on the source tick
                  if (tick)
                     next_count = count + 16'h0001;
            endcase
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         count      <= COUNT_CLEAR;
         prescale   <= 10'h000;
         trig_state <= TCB_IDLE;
         irq        <= 1'b0;
      end
      else
      begin
         count      <= next_count;
         prescale   <= next_prescale;
         trig_state <= next_trig_state;
         irq        <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs from flip-flops, except compare read, muxed on the buffer enable
   // reads show the buffered value when buffering is on
   assign o_compare_a_read      = i_compare_buffer_enable ? cmp_buf
                                                          : cmp_act;
   assign o_compare_a_active    = cmp_act;
   assign o_count               = count;
   assign o_timer_mode          = mode;
   assign o_overflow_irq_enable = ovf_en;
   assign o_running             = running;
   assign o_timer_irq           = irq;
endmodule : tcb_timer

// File: verif/tcb_pulse_src.sv
// external pulse source model driving the timer input pin
module tcb_pulse_src
(
   input  logic       i_clk,
   input  logic       i_en,
   input  logic [7:0] i_half,
   output logic       o_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt; // cycles spent at current level
   initial o_pin = 1'b0;
   initial cnt = 8'h00;
   // half of 4 or more keeps each level two cycles or longer
   always @(posedge i_clk)
   begin
      if (!i_en) cnt <= 8'h00;
      else if (cnt + 8'h01 >= i_half)
      begin
         cnt <= 8'h00;
         o_pin <= ~o_pin;
      end
      else cnt <= cnt + 8'h01;
   end
endmodule : tcb_pulse_src

// File: verif/tcb_timer_monitor.sv
// port checker for the compare-buffer timer
module tcb_timer_monitor
   import tcb_pkg::*;
(
   input logic              i_core_clk,
   input logic              i_rst,
   input logic              i_run_bit,
   input logic              i_compare_buffer_enable,
   input logic              i_compare_a_high_wr,
   input logic [BYTE_W-1:0] i_wdata,
   input logic [CNT_W-1:0]  o_compare_a_read,
   input logic [CNT_W-1:0]  o_compare_a_active,
   input logic [CNT_W-1:0]  o_count,
   input logic [MODE_W-1:0] o_timer_mode,
   input logic              o_overflow_irq_enable,
   input logic              o_running,
   input logic              o_timer_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////
   // interrupt only one cycle after count met active compare
   AST_IRQ_MATCH: assert property (o_timer_irq |->
      $past(o_count) == $past(o_compare_a_active))
      else $error("interrupt without compare match");
   AST_IRQ_CLR: assert property (o_timer_irq |->
      o_count == COUNT_CLEAR)
      else $error("count not cleared at match");
   // two stopped cycles: clear must have landed
   AST_STOP_CLR: assert property (!o_running && !$past(o_running) |->
      o_count == COUNT_CLEAR)
      else $error("count not cleared while stopped");
   AST_RUN_START: assert property (i_run_bit && !o_running |=>
      o_running)
      else $error("run bit did not start timer");
   // settings frozen once running
   AST_MODE_LOCK: assert property ($past(o_running) |->
      $stable(o_timer_mode) && $stable(o_overflow_irq_enable))
      else $error("mode changed while running");
   AST_UNBUF_WR: assert property (
      i_compare_a_high_wr && !i_compare_buffer_enable |=>
      o_compare_a_active[15:8] == $past(i_wdata))
      else $error("unbuffered write not active");
   AST_BUF_READ: assert property (
      i_compare_a_high_wr && i_compare_buffer_enable ##1
      i_compare_buffer_enable |-> o_compare_a_read[15:8] == $past(i_wdata))
      else $error("buffered read not last written");
   AST_BUF_STOP: assert property (
      i_compare_a_high_wr && i_compare_buffer_enable && !o_running &&
      !i_run_bit ##1 i_compare_buffer_enable |->
      o_compare_a_active == o_compare_a_read)
      else $error("stopped buffered write not active");
   // no match, no reload: active holds while buffered and running
   AST_BUF_HOLD: assert property (
      o_running && i_run_bit && i_compare_buffer_enable &&
      o_count != o_compare_a_active |=> $stable(o_compare_a_active))
      else $error("buffered active changed early");
   AST_BUF_LOAD: assert property (
      o_timer_irq && i_compare_buffer_enable &&
      $past(i_compare_buffer_enable) |->
      o_compare_a_active == o_compare_a_read)
      else $error("buffer not loaded at match");
   cover property (o_timer_irq && i_compare_buffer_enable);
   cover property (o_running && o_timer_mode == MODE_EVENT);
   cover property (o_running && o_timer_mode == MODE_WINDOW);
endmodule : tcb_timer_monitor

bind tcb_timer tcb_timer_monitor tcb_timer_monitor_inst (.i_core_clk,
   .i_rst, .i_run_bit, .i_compare_buffer_enable, .i_compare_a_high_wr,
   .i_wdata, .o_compare_a_read, .o_compare_a_active, .o_count,
   .o_timer_mode, .o_overflow_irq_enable, .o_running, .o_timer_irq);

// File: verif/tcb_timer_tb.sv
// self-checking bench for the compare-buffer timer
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
   $display("ERROR %0t: got %h want %h", $time, a, b); end end
module tcb_timer_tb;
   import tcb_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst, pin, run, dbf, ove, edg, rtg, mwr, lwr, hwr;
   logic        pen, ove_o, running, irq;
   logic [2:0]  msel, mode_o;
   logic [1:0]  csel;
   logic [7:0]  wd, half;
   logic [15:0] rd, act, cnt, v, mx, exp_act;
   logic [15:0] q[$];  // expected active compare per interrupt
   int          errors, check_count, cyc, irqs;
   logic [2:0]  mt[6] = '{MODE_EXT_TRIG, MODE_EXT_TRIG, MODE_EVENT,
                          MODE_EVENT, MODE_WINDOW, MODE_WINDOW};
   tcb_timer tcb_timer_inst (.i_core_clk(clk), .i_rst(rst),
      .i_external_input_pin(pin), .i_run_bit(run),
      .i_compare_buffer_enable(dbf), .i_overflow_irq_enable(ove),
      .i_operation_mode_select(msel), .i_source_clock_select(csel),
      .i_edge_level_select(edg), .i_retrigger_stop_enable(rtg),
      .i_mode_wr(mwr), .i_compare_a_low_wr(lwr), .i_compare_a_high_wr(hwr),
      .i_wdata(wd), .o_compare_a_read(rd), .o_compare_a_active(act),
      .o_count(cnt), .o_timer_mode(mode_o), .o_overflow_irq_enable(ove_o),
      .o_running(running), .o_timer_irq(irq));
   tcb_pulse_src tcb_pulse_src_inst (.i_clk(clk), .i_en(pen),
      .i_half(half), .o_pin(pin));
   ////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   // low byte then high byte, as the temp store requires
   task automatic wr16(input logic [15:0] d);
      @(negedge clk);
      lwr = 1'b1;
      wd = d[7:0];
      @(negedge clk);
      lwr = 1'b0;
      hwr = 1'b1;
      wd = d[15:8];
      @(negedge clk);
      hwr = 1'b0;
   endtask : wr16
   task automatic cfg(input logic [2:0] m, input logic e, input logic r);
      @(negedge clk);
      msel = m;
      edg = e;
      rtg = r;
      mwr = 1'b1;
      @(negedge clk);
      mwr = 1'b0;
   endtask : cfg
   // bounded wait; timeout catches a hang beyond it
   task automatic wait_irqs(input int n);
      for (int i = 0; i < 3000 && irqs < n; i++) @(negedge clk);
      `CHK(irqs >= n, 1'b1)
   endtask : wait_irqs
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // each interrupt takes the oldest note; none left means unexpected
   // sampled mid-cycle, away from the edge that launches the pulse
   always @(negedge clk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         errors++;
         conclude();
      end
      else if (!rst && irq === 1'b1)
      begin
         irqs++;
         if (q.size() == 0) `CHK(1'b0, 1'b1)
         else
         begin
            exp_act = q.pop_front();
            `CHK(act, exp_act)
         end
      end
   end
   initial
   begin
      v = 16'($urandom(32'h4a01));
      {rst, run, dbf, ove, edg, rtg, mwr, lwr, hwr, pen} = 10'h201;
      msel = MODE_RESET;
      csel = 2'h3;
      wd = 8'h00;
      half = 8'h04;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      `CHK(act, COMPARE_RESET)
      dbf = 1'b1;
      wr16(16'h0010);
      `CHK(act, 16'h0010)
      dbf = 1'b0;
      v = 16'($urandom_range(16'hFFFF, 16'h0100));
      wr16(v);
      `CHK(act, v)
      pen = 1'b1;
      // trigger, event and window modes with both edge or level selections
      foreach (mt[i])
      begin
         half = 8'($urandom_range(11, 4));
         csel = 2'($urandom_range(3, 2));
         cfg(mt[i], i[0], 1'b0);
         wr16(16'h0005);
         repeat (3) q.push_back(16'h0005);
         run = 1'b1;
         wait_irqs(irqs + 3);
         run = 1'b0;
         repeat (3) @(negedge clk);
         `CHK(cnt, COUNT_CLEAR)
         `CHK(mode_o, mt[i])
      end
      // buffered reload while running; config writes refused
      pen = 1'b0;
      csel = 2'h3;
      cfg(MODE_RESET, 1'b0, 1'b0);
      dbf = 1'b1;
      wr16(16'h0040);
      run = 1'b1;
      wr16(16'h0007);
      `CHK(act, 16'h0040)
      `CHK(rd, 16'h0007)
      ove = 1'b1;
      cfg(MODE_EVENT, 1'b1, 1'b1);
      `CHK(mode_o, MODE_RESET)
      `CHK(ove_o, 1'b0)
      q.push_back(16'h0007);
      q.push_back(16'h0007);
      wait_irqs(irqs + 2);
      // unbuffered value below count: no match before wrap
      dbf = 1'b0;
      wr16(16'h0080);
      repeat (80) @(negedge clk);
      wr16(16'h0004);
      repeat (250) @(negedge clk);
      `CHK(cnt > 16'h0080, 1'b1)
      // retrigger-stop: falling edge clears before a match
      run = 1'b0;
      half = 8'h08;
      pen = 1'b1;
      cfg(MODE_EXT_TRIG, 1'b0, 1'b1);
      `CHK(ove_o, 1'b1)
      wr16(16'h00FF);
      run = 1'b1;
      mx = 16'h0000;
      repeat (200)
      begin
         @(negedge clk);
         if (cnt > mx) mx = cnt;
      end
      `CHK(mx inside {[16'h0001:16'h000F]}, 1'b1)
      `CHK(q.size(), 0)
      conclude();
   end
endmodule : tcb_timer_tb
